//--- design/lxcd_blink_rom.sv
// small lookup memory: blink selector to frame count, registered read
`timescale 1ns/1ps
`default_nettype none
module lxcd_blink_rom
(
   input  wire logic       ref_clk,
   input  wire logic       ce,
   input  wire logic [2:0] sel,
   output logic      [7:0] frames
);
   logic [7:0] rom [0:7];
   assign rom[0] = lxcd_pkg::lxcd_frames(lxcd_pkg::BLINK_MS0);
   assign rom[1] = lxcd_pkg::lxcd_frames(lxcd_pkg::BLINK_MS1);
   assign rom[2] = lxcd_pkg::lxcd_frames(lxcd_pkg::BLINK_MS2);
   assign rom[3] = lxcd_pkg::lxcd_frames(lxcd_pkg::BLINK_MS3);
   assign rom[4] = lxcd_pkg::lxcd_frames(lxcd_pkg::BLINK_MS4);
   assign rom[5] = lxcd_pkg::lxcd_frames(lxcd_pkg::BLINK_MS5);
   assign rom[6] = lxcd_pkg::lxcd_frames(lxcd_pkg::BLINK_MS6);
   assign rom[7] = lxcd_pkg::lxcd_frames(lxcd_pkg::BLINK_MS7);

   always_ff @(posedge ref_clk)
   begin
      if (ce)
         frames <= rom[sel];
   end
endmodule // lxcd_blink_rom
`default_nettype wire

//--- design/lxcd_decoder.sv
// extended command decoder: blink period, cursor auto move, glyph set
// How it works
// - command 50h loads blink selector bits 2..0
// - two operands precede command; second ignored
// - blink period table, 0.066 to 2 seconds
// - command 60h bit 0 sets cursor auto-move
// - auto-move steps cursor after each display data byte
// - command 70h takes glyph selector bits 1..0
// - 10 first set, 11 second, else default
// - chip variant fixes the default glyph set
// - attribute blink bit blinks the character form
`timescale 1ns/1ps
`default_nettype none
module lxcd_decoder
#(
   parameter bit DEFAULT_SECOND = 1'b0
)
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       data_wr,
   input  wire logic       cmd_wr,
   input  wire logic [7:0] host_byte,
   input  wire logic       frame_tick,
   input  wire logic       disp_data_xfer,
   input  wire logic       cursor_down,
   input  wire logic [3:0] attr_byte,
   output logic      [2:0] blink_sel,
   output logic            cursor_auto,
   output logic            glyph_second,
   output logic            cursor_step_up,
   output logic            cursor_step_down,
   output logic            blink_phase,
   output logic            char_blank,
   output logic      [2:0] attr_form
);
   logic [7:0]        op_first_q;
   logic [7:0]        op_second_q;
   lxcd_pkg::lxcd_op_t op_cnt_q;
   lxcd_pkg::lxcd_op_t op_cnt_d;
   logic [1:0]        glyph_sel_q;
   logic [7:0]        frame_cnt_q;
   logic [7:0]        period_frames;
   logic              ops_ready;
   logic              is_blink_cmd;
   logic              is_auto_cmd;
   logic              is_glyph_cmd;
   logic              period_done;
   logic              attr_blinks;

   // operand tracking: keep first byte and the latest byte after it
   assign ops_ready    = (op_cnt_q == lxcd_pkg::LXCD_OP_TWO);
   // second operand never inspected
   assign is_blink_cmd = cmd_wr && ops_ready && host_byte == lxcd_pkg::CMD_BLINK_TIME;
   assign is_auto_cmd  = cmd_wr && ops_ready && host_byte == lxcd_pkg::CMD_CURSOR_AUTO;
   assign is_glyph_cmd = cmd_wr && ops_ready && host_byte == lxcd_pkg::CMD_GLYPH_SET;

   always_comb
   begin
      op_cnt_d = op_cnt_q;
      if (cmd_wr)
         op_cnt_d = lxcd_pkg::LXCD_OP_EMPTY;
      else if (data_wr)
         op_cnt_d = (op_cnt_q == lxcd_pkg::LXCD_OP_EMPTY) ? lxcd_pkg::LXCD_OP_ONE
                                                         : lxcd_pkg::LXCD_OP_TWO;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         op_cnt_q    <= lxcd_pkg::LXCD_OP_EMPTY;
         op_first_q  <= 8'h00;
         op_second_q <= 8'h00;
      end
      else if (ce)
      begin
         op_cnt_q <= op_cnt_d;
         if (data_wr && !cmd_wr)
         begin
            op_first_q  <= (op_cnt_q == lxcd_pkg::LXCD_OP_EMPTY) ? host_byte : op_first_q;
            op_second_q <= (op_cnt_q == lxcd_pkg::LXCD_OP_EMPTY) ? op_second_q : host_byte;
         end
      end
   end

   // settings registers
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         blink_sel   <= lxcd_pkg::BLINK_SEL_RST;
         cursor_auto <= 1'b0;
         glyph_sel_q <= lxcd_pkg::GLYPH_SEL_RST;
      end
      else if (ce)
      begin
         if (is_blink_cmd)
            blink_sel <= op_first_q[lxcd_pkg::BLINK_SEL_MSB:0];
         if (is_auto_cmd)
            cursor_auto <= op_first_q[lxcd_pkg::AUTO_BIT];
         if (is_glyph_cmd)
            glyph_sel_q <= op_first_q[lxcd_pkg::GLYPH_SEL_MSB:0];
      end
   end

   // glyph set choice with variant default
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         glyph_second <= DEFAULT_SECOND;
      else if (ce)
         glyph_second <= (glyph_sel_q == lxcd_pkg::GLYPH_SECOND) ? 1'b1 :
                         (glyph_sel_q == lxcd_pkg::GLYPH_FIRST)  ? 1'b0 : DEFAULT_SECOND;
   end

   // cursor stepping on each display data byte
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cursor_step_up   <= 1'b0;
         cursor_step_down <= 1'b0;
      end
      else if (ce)
      begin
         cursor_step_up   <= cursor_auto && disp_data_xfer && !cursor_down;
         cursor_step_down <= cursor_auto && disp_data_xfer && cursor_down;
      end
   end

   // blink timing in frames
   lxcd_blink_rom u_rom
   (
      .ref_clk (ref_clk),
      .ce      (ce),
      .sel     (blink_sel),
      .frames  (period_frames)
   );

   assign period_done = frame_tick && (frame_cnt_q + 8'h01 >= period_frames);

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         frame_cnt_q <= 8'h00;
         blink_phase <= 1'b0;
      end
      else if (ce && frame_tick)
      begin
         frame_cnt_q <= period_done ? 8'h00 : frame_cnt_q + 8'h01;
         if (period_done)
            blink_phase <= ~blink_phase;
      end
   end

   // attribute blink: blank in off phase, form from low bits
   assign attr_blinks = attr_byte[lxcd_pkg::ATTR_BLINK_POS];

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         char_blank <= 1'b0;
         attr_form  <= 3'h0;
      end
      else if (ce)
      begin
         char_blank <= attr_blinks && blink_phase;
         attr_form  <= attr_byte[2:0];
      end
   end

   blink_cmd_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && is_blink_cmd |=> blink_sel == $past(op_first_q[2:0]))
      else $error("blink selector not loaded");
   auto_cmd_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && is_auto_cmd |=> cursor_auto == $past(op_first_q[0]))
      else $error("auto move not loaded");
   glyph_cmd_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && is_glyph_cmd |=> glyph_sel_q == $past(op_first_q[1:0]))
      else $error("glyph selector not loaded");
   no_ops_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && cmd_wr && !ops_ready |=> $stable(blink_sel) && $stable(cursor_auto))
      else $error("command took effect without operands");
   op_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && cmd_wr |=> op_cnt_q == lxcd_pkg::LXCD_OP_EMPTY)
      else $error("operand count not cleared by command");
   step_up_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && cursor_auto && disp_data_xfer && !cursor_down |=> cursor_step_up)
      else $error("cursor did not step");
   step_down_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && cursor_auto && disp_data_xfer && cursor_down |=> cursor_step_down)
      else $error("cursor did not step down");
   no_step_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && !cursor_auto |=> !cursor_step_up && !cursor_step_down)
      else $error("cursor stepped while disabled");
   glyph_map_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && glyph_sel_q[1] |=> glyph_second == $past(glyph_sel_q[0]))
      else $error("glyph set mapping wrong");
   glyph_dflt_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && !glyph_sel_q[1] |=> glyph_second == DEFAULT_SECOND)
      else $error("default glyph set not in use");
   blink_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      !frame_tick |=> $stable(blink_phase))
      else $error("blink phase moved without a frame");
   blink_flip_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && period_done |=> blink_phase != $past(blink_phase))
      else $error("blink phase did not flip at period end");
   blank_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && !attr_byte[3] |=> !char_blank)
      else $error("non blinking character blanked");
   form_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce |=> attr_form == $past(attr_byte[2:0]))
      else $error("attribute form not passed on");
   freeze_a: assert property (@(posedge ref_clk) disable iff (rst)
      !ce |=> $stable(blink_sel) && $stable(cursor_auto) && $stable(glyph_second))
      else $error("settings moved while clock enable low");
endmodule // lxcd_decoder
`default_nettype wire

//--- design/lxcd_pkg.sv
// package with command codes, field positions, reset values and blink timing
`default_nettype none
package lxcd_pkg;
   localparam logic [7:0] CMD_BLINK_TIME  = 8'h50;
   localparam logic [7:0] CMD_CURSOR_AUTO = 8'h60;
   localparam logic [7:0] CMD_GLYPH_SET   = 8'h70;
   localparam int BLINK_SEL_MSB  = 2;
   localparam int AUTO_BIT       = 0;
   localparam int GLYPH_SEL_MSB  = 1;
   localparam int ATTR_BLINK_POS = 3;
   localparam logic [2:0] BLINK_SEL_RST = 3'h0;
   localparam logic [1:0] GLYPH_SEL_RST = 2'h0;
   localparam logic [1:0] GLYPH_FIRST   = 2'h2;
   localparam logic [1:0] GLYPH_SECOND  = 2'h3;
   // nominal frame rate for the blink table
   localparam int FRAME_RATE_HZ = 60;
   // blink periods in milliseconds, selector 0..7
   localparam int BLINK_MS0 = 66;
   localparam int BLINK_MS1 = 250;
   localparam int BLINK_MS2 = 500;
   localparam int BLINK_MS3 = 750;
   localparam int BLINK_MS4 = 1000;
   localparam int BLINK_MS5 = 1250;
   localparam int BLINK_MS6 = 1500;
   localparam int BLINK_MS7 = 2000;
   // frame counts derived from milliseconds and frame rate, least time rounded up
   function automatic logic [7:0] lxcd_frames(input int ms);
      lxcd_frames = 8'((ms * FRAME_RATE_HZ + 999) / 1000);
   endfunction
   typedef enum logic [1:0] {
      LXCD_OP_EMPTY = 2'b00,
      LXCD_OP_ONE   = 2'b01,
      LXCD_OP_TWO   = 2'b11
   } lxcd_op_t;
endpackage
`default_nettype wire

//--- testbench/lxcd_decoder_tb.sv
// self-checking bench for the extended command decoder
`timescale 1ns/1ps
`default_nettype none
module lxcd_decoder_tb;
   logic       ref_clk, rst, ce, frame_tick, xfer, down, data_wr, cmd_wr;
   logic [7:0] host_byte, op1;
   logic [3:0] attr_byte;
   logic [2:0] blink_sel, attr_form;
   logic       auto, glyph2, up_s, dn_s, phase, blank, glyph2_alt;
   int         err_total, total_checks, cycles, seed;
   lxcd_host_model host (.ref_clk(ref_clk), .data_wr(data_wr), .cmd_wr(cmd_wr),
      .host_byte(host_byte));
   lxcd_decoder #(.DEFAULT_SECOND(1'b0)) dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
      .data_wr(data_wr), .cmd_wr(cmd_wr), .host_byte(host_byte), .frame_tick(frame_tick),
      .disp_data_xfer(xfer), .cursor_down(down), .attr_byte(attr_byte),
      .blink_sel(blink_sel), .cursor_auto(auto), .glyph_second(glyph2),
      .cursor_step_up(up_s), .cursor_step_down(dn_s), .blink_phase(phase),
      .char_blank(blank), .attr_form(attr_form));
   // second chip variant, defaulting to the second glyph set
   lxcd_decoder #(.DEFAULT_SECOND(1'b1)) dut_alt (.ref_clk(ref_clk), .rst(rst), .ce(ce),
      .data_wr(data_wr), .cmd_wr(cmd_wr), .host_byte(host_byte), .frame_tick(frame_tick),
      .disp_data_xfer(xfer), .cursor_down(down), .attr_byte(attr_byte),
      .blink_sel(), .cursor_auto(), .glyph_second(glyph2_alt),
      .cursor_step_up(), .cursor_step_down(), .blink_phase(),
      .char_blank(), .attr_form());
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %h seen %h", what, exp, seen);
         err_total++;
      end
   endtask
   task automatic close_out;
      if (err_total == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // frames per blink period, least time rounded up
   function automatic int frames_for(input int s);
      int ms [8] = '{66, 250, 500, 750, 1000, 1250, 1500, 2000};
      return (ms[s] * lxcd_pkg::FRAME_RATE_HZ + 999) / 1000;
   endfunction
   // glyph set in use: 10 first, 11 second, else the variant default
   function automatic logic glyph_exp(input logic [1:0] sel, input logic dflt);
      return sel[1] ? sel[0] : dflt;
   endfunction
   task automatic tick(input int k);
      repeat (k)
      begin
         @(negedge ref_clk) frame_tick = 1'b1;
         @(negedge ref_clk) frame_tick = 1'b0;
      end
      @(negedge ref_clk);
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         err_total++;
         close_out();
      end
   end
   initial
   begin
      seed = 70;
      {rst, ce, frame_tick, xfer, down, attr_byte} = 9'h180;
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk) rst = 1'b0;
      check("glyph_second", 8'(glyph2), 8'h00);
      check("glyph_alt", 8'(glyph2_alt), 8'h01);
      check("cursor_auto", 8'(auto), 8'h00);
      check("blink_sel", 8'(blink_sel), 8'(lxcd_pkg::BLINK_SEL_RST));
      for (int s = 0; s < 8; s++)
      begin
         op1 = 8'($random(seed));
         host.op_cmd({op1[7:3], 3'(s)}, 8'($random(seed)), lxcd_pkg::CMD_BLINK_TIME);
         repeat (3) @(negedge ref_clk);
         check("blink_sel", 8'(blink_sel), 8'(s));
         tick(frames_for(s) - 1);
         check("blink_phase", 8'(phase), 8'(s % 2));
         tick(1);
         check("blink_phase", 8'(phase), 8'((s + 1) % 2));
         attr_byte = op1[3:0];
         repeat (2) @(negedge ref_clk);
         check("char_blank", 8'(blank), 8'(op1[3] & ((s + 1) % 2)));
         check("attr_form", 8'(attr_form), 8'(op1[2:0]));
      end
      // frozen: neither the command nor the frames may count
      ce = 1'b0;
      host.op_cmd(8'h03, 8'h00, lxcd_pkg::CMD_BLINK_TIME);
      tick(130);
      ce = 1'b1;
      check("blink_sel", 8'(blink_sel), 8'h07);
      check("blink_phase", 8'(phase), 8'h00);
      for (int k = 0; k < 8; k++)
      begin
         op1 = 8'($random(seed));
         host.op_cmd(op1, 8'($random(seed)), lxcd_pkg::CMD_CURSOR_AUTO);
         repeat (3) @(negedge ref_clk);
         check("cursor_auto", 8'(auto), 8'(op1[0]));
         down = op1[1];
         @(negedge ref_clk) xfer = 1'b1;
         @(negedge ref_clk) xfer = 1'b0;
         check("step_up", 8'(up_s), 8'(op1[0] & !op1[1]));
         check("step_down", 8'(dn_s), 8'(op1[0] & op1[1]));
         @(negedge ref_clk);
         check("step_pair", {6'h0, up_s, dn_s}, 8'h00);
         op1 = {op1[7:2], 2'(k)};
         host.op_cmd(op1, 8'($random(seed)), lxcd_pkg::CMD_GLYPH_SET);
         repeat (3) @(negedge ref_clk);
         check("glyph_second", 8'(glyph2), 8'(k % 4 == 3));
         check("glyph_alt", 8'(glyph2_alt), 8'(glyph_exp(2'(k), 1'b1)));
      end
      host.send(8'h02, 1'b0);
      host.send(lxcd_pkg::CMD_GLYPH_SET, 1'b1);
      host.op_cmd(8'h02, 8'h02, 8'h71);
      repeat (3) @(negedge ref_clk);
      check("glyph_second", 8'(glyph2), 8'h01);
      check("glyph_alt", 8'(glyph2_alt), 8'h01);
      // reset in mid-run, then a command on the first edges after release
      @(negedge ref_clk) rst = 1'b1;
      @(negedge ref_clk) rst = 1'b0;
      check("glyph_second", 8'(glyph2), 8'h00);
      check("cursor_auto", 8'(auto), 8'h00);
      check("blink_sel", 8'(blink_sel), 8'(lxcd_pkg::BLINK_SEL_RST));
      host.op_cmd(8'h05, 8'($random(seed)), lxcd_pkg::CMD_BLINK_TIME);
      repeat (3) @(negedge ref_clk);
      check("blink_sel", 8'(blink_sel), 8'h05);
      close_out();
   end
endmodule // lxcd_decoder_tb
`default_nettype wire

//--- testbench/lxcd_host_model.sv
// host model: sends operand and command bytes on the parallel port
`timescale 1ns/1ps
`default_nettype none
module lxcd_host_model
(
   input  wire logic       ref_clk,
   output logic            data_wr,
   output logic            cmd_wr,
   output logic      [7:0] host_byte
);
   initial
   begin
      data_wr = 1'b0;
      cmd_wr = 1'b0;
      host_byte = 8'h00;
   end
   // released bus shows the inverse of the last byte
   task automatic send(input logic [7:0] b, input bit is_cmd);
      @(negedge ref_clk);
      data_wr = !is_cmd;
      cmd_wr = is_cmd;
      host_byte = b;
      @(negedge ref_clk);
      data_wr = 1'b0;
      cmd_wr = 1'b0;
      host_byte = ~b;
   endtask
   task automatic op_cmd(input logic [7:0] first_op, input logic [7:0] second_op,
      input logic [7:0] c);
      send(first_op, 1'b0);
      send(second_op, 1'b0);
      send(c, 1'b1);
   endtask
endmodule // lxcd_host_model
`default_nettype wire
